// [hw/ipvs_map.vh]
// Register offsets, field positions, reset values and vector constants for the priority and vector block
`ifndef IPVS_MAP_VH
`define IPVS_MAP_VH
`define IPVS_OFF_PRIO_A     12'h000
`define IPVS_OFF_PRIO_D     12'h004
`define IPVS_OFF_STATUS     12'h008
`define IPVS_OFF_ENABLE     12'h00c
`define IPVS_OFF_EVT_STAT   12'h010
`define IPVS_OFF_EVT_MASK   12'h014
`define IPVS_OFF_VEC_BASE   12'h018
`define IPVS_PRIO_RESET     3'h4
`define IPVS_PRIO_A_MASK    16'h7777
`define IPVS_PRIO_D_MASK    16'h0777
`define IPVS_LVL_LSB        8
`define IPVS_VEC_LSB        0
`define IPVS_VEC_OFFSET     8
`define IPVS_NSRC           7
`define IPVS_SRC_EXT0       0
`define IPVS_SRC_CAP1       1
`define IPVS_SRC_CMP1       2
`define IPVS_SRC_TMR1       3
`define IPVS_SRC_UART1TX    4
`define IPVS_SRC_ADC1       5
`define IPVS_SRC_DMA1       6
`define IPVS_EVT_NEW_PEND   0
`define IPVS_EVT_LVL_CHG    1
`endif

// [hw/ipvs_arbiter.v]
// Combinational search for the highest-priority enabled, requesting source
`include "ipvs_map.vh"
module ipvs_arbiter #(
  parameter NSRC = 7
) (
  // Sources
  input  wire [NSRC-1:0]   req,
  input  wire [NSRC-1:0]   en,
  input  wire [3*NSRC-1:0] prio,
  // Winner
  output reg               found,
  output reg  [2:0]        win_prio,
  output reg  [6:0]        win_idx
);
  integer i;
  always @* begin
    found    = 1'b0;
    win_prio = 3'h0;
    win_idx  = 7'h00;
    // Lowest index wins a tie at equal priority
    for (i = 0; i < NSRC; i = i + 1) begin
      if (req[i] && en[i] && prio[3*i +: 3] != 3'h0 && prio[3*i +: 3] > win_prio) begin
        found    = 1'b1;
        win_prio = prio[3*i +: 3];
        win_idx  = i[6:0];
      end
    end
  end
endmodule

// [hw/ipvs_evt.v]
// Sticky event flags with write-one-to-clear, mask and level interrupt
module ipvs_evt #(
  parameter N = 2
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Events and software access
  input  wire [N-1:0] evt,
  input  wire [N-1:0] clr,
  input  wire         mask_we,
  input  wire [N-1:0] mask_wdata,
  // State
  output reg  [N-1:0] stat_q,
  output reg  [N-1:0] mask_q,
  output reg          irq_q
);
  wire [N-1:0] stat_d = (stat_q & ~clr) | evt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= {N{1'b0}};
      mask_q <= {N{1'b0}};
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      if (mask_we) begin
        mask_q <= mask_wdata;
      end
      irq_q <= |(stat_d & (mask_we ? mask_wdata : mask_q));
    end
  end
endmodule

// [hw/ipvs_top.v]
// APB register block for source priorities, enables and pending vector status
//
// Our own choices: the register offsets and the APB slave port.
`include "ipvs_map.vh"
// Notes on behaviour
// RULE1: Each source has a 3-bit priority; code 111 is level 7, highest.
// RULE2: Code 001 is level 1, lowest active; other codes equal their value.
// RULE3: Priority code 000 disables the source; it never becomes pending.
// RULE4: Priority fields are read/write and reset to 100 (level 4).
// RULE5: Register A: timer1 14-12, compare1 10-8, capture1 6-4, external0 2-0.
// RULE6: Register D: dma1 10-8, adc1 6-4, uart1 tx 2-0; 15-11 unimplemented.
// RULE7: Status bits 11-8 give the new 4-bit CPU priority level.
// RULE8: Status bits 6-0 give pending vector number minus eight; the code gives vec_base_q plus the source index instead.
// RULE9: Status bits are read-only, reset to zero; 15-12 and 7 unimplemented.
// RULE10: Each source has an enable bit; 0 blocks its request.
// RULE11: Unimplemented bits ignore writes and read as zero.
// RULE12: Highest-priority enabled requesting source is presented as pending.
module ipvs_top #(
  parameter NSRC = `IPVS_NSRC
) (
  // Clock and reset
  input  wire            pclk,
  input  wire            presetn,
  // APB slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // Interrupt sources
  input  wire [NSRC-1:0] src_req,
  // To the CPU core
  output reg             cpu_irq_pending,
  output reg  [3:0]      cpu_level,
  output reg  [6:0]      cpu_vector,
  output wire            evt_irq
);
  reg  [15:0]     prio_a_q;
  reg  [15:0]     prio_d_q;
  reg  [NSRC-1:0] enable_q;
  reg  [6:0]      vec_base_q;
  reg  [15:0]     status_q;
  wire [3*NSRC-1:0] prio_vec;
  wire            found;
  wire [2:0]      win_prio;
  wire [6:0]      win_idx;
  wire [1:0]      evt_stat;
  wire [1:0]      evt_mask;
  wire            wr_acc;
  reg  [15:0]     status_d;
  reg  [31:0]     rdata_d;
  reg             err_d;

  // Write mask leaves unimplemented bits at zero
  function [15:0] wmask;
    input [15:0] data;
    input [15:0] mask;
    begin
      wmask = data & mask;
    end
  endfunction

  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a == `IPVS_OFF_PRIO_A) || (a == `IPVS_OFF_PRIO_D) || (a == `IPVS_OFF_STATUS) ||
                (a == `IPVS_OFF_ENABLE) || (a == `IPVS_OFF_EVT_STAT) || (a == `IPVS_OFF_EVT_MASK) ||
                (a == `IPVS_OFF_VEC_BASE);
    end
  endfunction

  assign wr_acc = psel && penable && pwrite && addr_ok(paddr);

  // Priority fields per source index
  assign prio_vec[3*`IPVS_SRC_EXT0    +: 3] = prio_a_q[2:0];   // RULE5
  assign prio_vec[3*`IPVS_SRC_CAP1    +: 3] = prio_a_q[6:4];   // RULE5
  assign prio_vec[3*`IPVS_SRC_CMP1    +: 3] = prio_a_q[10:8];  // RULE5
  assign prio_vec[3*`IPVS_SRC_TMR1    +: 3] = prio_a_q[14:12]; // RULE5
  assign prio_vec[3*`IPVS_SRC_UART1TX +: 3] = prio_d_q[2:0];   // RULE6
  assign prio_vec[3*`IPVS_SRC_ADC1    +: 3] = prio_d_q[6:4];   // RULE6
  assign prio_vec[3*`IPVS_SRC_DMA1    +: 3] = prio_d_q[10:8];  // RULE6

  ipvs_arbiter #(
    .NSRC (NSRC)
  ) u_arb (
    .req      (src_req),
    .en       (enable_q),
    .prio     (prio_vec),
    .found    (found),
    .win_prio (win_prio),
    .win_idx  (win_idx)
  );

  // Software-visible control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_a_q   <= {1'b0, `IPVS_PRIO_RESET, 1'b0, `IPVS_PRIO_RESET,
                     1'b0, `IPVS_PRIO_RESET, 1'b0, `IPVS_PRIO_RESET}; // RULE4
      prio_d_q   <= {5'h00, `IPVS_PRIO_RESET, 1'b0, `IPVS_PRIO_RESET,
                     1'b0, `IPVS_PRIO_RESET}; // RULE4
      enable_q   <= {NSRC{1'b0}};
      vec_base_q <= 7'h00;
    end else if (wr_acc) begin
      case (paddr)
        `IPVS_OFF_PRIO_A: begin
          prio_a_q <= wmask(pwdata[15:0], `IPVS_PRIO_A_MASK); // RULE11
        end
        `IPVS_OFF_PRIO_D: begin
          prio_d_q <= wmask(pwdata[15:0], `IPVS_PRIO_D_MASK); // RULE11
        end
        `IPVS_OFF_ENABLE: begin
          enable_q <= pwdata[NSRC-1:0]; // RULE10
        end
        `IPVS_OFF_VEC_BASE: begin
          vec_base_q <= pwdata[6:0];
        end
        default: begin
          enable_q <= enable_q;
        end
      endcase
    end
  end

  // Pending level and vector; nothing pending shows level 0 and code 0
  always @* begin
    status_d = 16'h0000;
    if (found) begin // RULE3 RULE12
      status_d[`IPVS_LVL_LSB +: 4] = {1'b0, win_prio};               // RULE1 RULE2 RULE7
      status_d[`IPVS_VEC_LSB +: 7] = vec_base_q + win_idx;           // RULE8
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q        <= 16'h0000; // RULE9
      cpu_irq_pending <= 1'b0;
      cpu_level       <= 4'h0;
      cpu_vector      <= 7'h00;
    end else begin
      status_q        <= status_d;
      cpu_irq_pending <= found;
      cpu_level       <= status_d[`IPVS_LVL_LSB +: 4];
      cpu_vector      <= status_d[`IPVS_VEC_LSB +: 7];
    end
  end

  // Events: a source becomes pending while none was pending, or the pending level changes
  wire [1:0] evt_in;
  assign evt_in[`IPVS_EVT_NEW_PEND] = found && !cpu_irq_pending;
  assign evt_in[`IPVS_EVT_LVL_CHG]  = status_d[`IPVS_LVL_LSB +: 4] != status_q[`IPVS_LVL_LSB +: 4];

  wire evt_irq_w;
  ipvs_evt #(
    .N (2)
  ) u_evt (
    .pclk       (pclk),
    .presetn    (presetn),
    .evt        (evt_in),
    .clr        ((wr_acc && paddr == `IPVS_OFF_EVT_STAT) ? pwdata[1:0] : 2'b00),
    .mask_we    (wr_acc && paddr == `IPVS_OFF_EVT_MASK),
    .mask_wdata (pwdata[1:0]),
    .stat_q     (evt_stat),
    .mask_q     (evt_mask),
    .irq_q      (evt_irq_w)
  );
  assign evt_irq = evt_irq_w;

  // APB read data and error; status register ignores writes
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d   = !addr_ok(paddr);
    case (paddr)
      `IPVS_OFF_PRIO_A:   rdata_d[15:0]     = prio_a_q;
      `IPVS_OFF_PRIO_D:   rdata_d[15:0]     = prio_d_q;
      `IPVS_OFF_STATUS:   rdata_d[15:0]     = status_q; // RULE9
      `IPVS_OFF_ENABLE:   rdata_d[NSRC-1:0] = enable_q;
      `IPVS_OFF_EVT_STAT: rdata_d[1:0]      = evt_stat;
      `IPVS_OFF_EVT_MASK: rdata_d[1:0]      = evt_mask;
      `IPVS_OFF_VEC_BASE: rdata_d[6:0]      = vec_base_q;
      default:            rdata_d           = 32'h0000_0000;
    endcase
  end

  // Zero-wait answer: pready registered high during setup, so access completes in one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && err_d;
      prdata  <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
    end
  end
endmodule

// [dv/ipvs_properties.sv]
// Port assertions for the priority and vector block
`include "ipvs_map.vh"
module ipvs_properties #(
  parameter NSRC = 7
) (
  // Clock, reset and APB
  input logic            pclk,
  input logic            presetn,
  input logic            psel,
  input logic            penable,
  input logic            pwrite,
  input logic [11:0]     paddr,
  input logic [31:0]     pwdata,
  input logic [31:0]     prdata,
  input logic            pready,
  input logic            pslverr,
  // Sources and core side
  input logic [NSRC-1:0] src_req,
  input logic            cpu_irq_pending,
  input logic [3:0]      cpu_level,
  input logic [6:0]      cpu_vector,
  input logic            evt_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_ok = pready && !pwrite;
  chk_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  chk_err_unmapped: assert property (pready && paddr > `IPVS_OFF_VEC_BASE |-> pslverr) else $error("no error");
  chk_a_read_zero: assert property (rd_ok && paddr == `IPVS_OFF_PRIO_A |-> (prdata & 32'hffff8888) == 0)
    else $error("prio a spare bits set");
  chk_d_read_zero: assert property (rd_ok && paddr == `IPVS_OFF_PRIO_D |-> (prdata & 32'hfffff888) == 0)
    else $error("prio d spare bits set");
  chk_stat_read_zero: assert property (rd_ok && paddr == `IPVS_OFF_STATUS |-> (prdata & 32'hfffff080) == 0)
    else $error("status spare bits set");
  chk_idle_clear: assert property (!cpu_irq_pending |-> cpu_level == 0 && cpu_vector == 0)
    else $error("idle status not zero");
  chk_pend_level: assert property (cpu_irq_pending |-> cpu_level inside {[1:7]})
    else $error("pending level out of range");
  chk_no_request: assert property (src_req == 0 |=> !cpu_irq_pending) else $error("pending without request");
  cover property (cpu_irq_pending && cpu_level == 7);
  cover property (pready && pslverr);
  cover property ($rose(evt_irq));
endmodule
bind ipvs_top ipvs_properties #(.NSRC(NSRC)) u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .src_req, .cpu_irq_pending, .cpu_level, .cpu_vector, .evt_irq);

// [dv/ipvs_cpu_model.sv]
// Core-side model that takes the pending vector
module ipvs_cpu_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       pending,
  input  logic [6:0] vector,
  output logic [6:0] taken_q
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) taken_q <= 7'h00;
    else if (pending) taken_q <= vector;
  end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the priority and vector block
`include "ipvs_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, a_irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [6:0]  src_req = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, cpu_irq_pending, evt_irq;
  wire  [3:0]  cpu_level;
  wire  [6:0]  cpu_vector, taken;
  int          n_fail = 0, comparisons = 0;
  ipvs_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .src_req, .cpu_irq_pending, .cpu_level, .cpu_vector, .evt_irq);
  ipvs_cpu_model cpu (.pclk, .presetn, .pending(cpu_irq_pending), .vector(cpu_vector), .taken_q(taken));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      n_fail++;
      end_of_test;
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(exp, rd, "read data");
  endtask
  task t_reset;
    rdc(`IPVS_OFF_PRIO_A, 32'h4444);
    rdc(`IPVS_OFF_PRIO_D, 32'h0444);
    rdc(`IPVS_OFF_STATUS, 32'h0);
  endtask
  task t_fields;
    apb(1, `IPVS_OFF_PRIO_A, 32'hffffffff);
    rdc(`IPVS_OFF_PRIO_A, 32'h7777);
    apb(1, `IPVS_OFF_PRIO_D, 32'hffffffff);
    rdc(`IPVS_OFF_PRIO_D, 32'h0777);
    apb(1, `IPVS_OFF_STATUS, 32'hffffffff);
    rdc(`IPVS_OFF_STATUS, 32'h0);
  endtask
  task t_arb;
    apb(1, `IPVS_OFF_PRIO_D, 32'h0);
    apb(1, `IPVS_OFF_PRIO_A, 32'h7123);
    apb(1, `IPVS_OFF_ENABLE, 32'h7f);
    src_req <= 7'h7f;
    rdc(`IPVS_OFF_STATUS, 32'h0703);
    chk(32'h3, {25'h0, taken}, "taken vector");
    apb(1, `IPVS_OFF_PRIO_A, 32'h0123);
    rdc(`IPVS_OFF_STATUS, 32'h0300);
    apb(1, `IPVS_OFF_ENABLE, 32'h7e);
    rdc(`IPVS_OFF_STATUS, 32'h0201);
    src_req <= 7'h04;
    rdc(`IPVS_OFF_STATUS, 32'h0102);
    src_req <= 7'h7f;
    apb(1, `IPVS_OFF_PRIO_D, 32'h0500);
    rdc(`IPVS_OFF_STATUS, 32'h0506);
  endtask
  task t_irq;
    apb(0, `IPVS_OFF_EVT_STAT, 0);
    chk(32'h3, rd, "event flags");
    apb(1, `IPVS_OFF_EVT_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    a_irq = evt_irq;
    apb(1, `IPVS_OFF_EVT_MASK, 32'h3);
    rdc(`IPVS_OFF_EVT_MASK, 32'h3);
    repeat (2) @(posedge pclk);
    chk(32'h1, {31'h0, a_irq ^ evt_irq}, "mask effect");
    apb(1, `IPVS_OFF_EVT_STAT, 32'h3);
    repeat (2) @(posedge pclk);
    chk(32'h0, {31'h0, evt_irq}, "irq after clear");
    rdc(`IPVS_OFF_EVT_STAT, 32'h0);
  endtask
  task t_vec;
    apb(1, `IPVS_OFF_VEC_BASE, 32'h10);
    rdc(`IPVS_OFF_VEC_BASE, 32'h10);
    rdc(`IPVS_OFF_STATUS, 32'h0516);
    chk(32'h5, {28'h0, cpu_level}, "cpu level");
    chk(32'h16, {25'h0, cpu_vector}, "cpu vector");
    chk(32'h16, {25'h0, taken}, "taken vector");
    rdc(`IPVS_OFF_ENABLE, 32'h7e);
    apb(1, `IPVS_OFF_PRIO_A, 32'h0050);
    rdc(`IPVS_OFF_STATUS, 32'h0511);
    chk(32'h1, {31'h0, cpu_irq_pending}, "pending");
  endtask
  task t_unmapped;
    apb(0, 12'h01c, 0);
    chk(32'h1, {31'h0, er}, "slave error");
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_fields;
    t_arb;
    t_irq;
    t_vec;
    t_unmapped;
    end_of_test;
  end
endmodule
